// file: shared/tcc_pkg.sv
// Constants, register map and carrier types for the telemetry calculator.
`default_nettype none
package tcc_pkg;
	// Structure of the converter.
	localparam int NPH = 7;
	localparam int NCH = 2;
	localparam int ADC_W = 12;
	localparam int IIN_W = 13;
	localparam int TEL_W = 16;
	localparam int CUR_W = 16;
	localparam int SEL_W = 8;
	localparam int IDX_W = 3;
	localparam int GAIN_W = 16;
	localparam int FEG_W = 4;
	localparam int DG_W = 8;
	localparam int ADDR_W = 8;

	// Arithmetic widths.
	localparam int GAIN_FRAC = 8;
	localparam int SUM_W = 16;
	localparam int OSUM_W = 19;
	localparam int DIV_W = 24;
	localparam int REM_W = GAIN_W + 1;
	localparam int RES_W = 27;
	localparam int IINS_W = 22;
	localparam int DIV_STEPS = DIV_W;
	localparam logic [4:0] DIV_LAST = 5'(DIV_STEPS - 1);

	// Current telemetry is in 1/16 A steps.
	localparam int CUR_FRAC = 4;
	localparam int CUR_LSB_PER_A = 1 << CUR_FRAC;
	localparam int PH_MIN_A = -10;
	localparam int PH_MAX_A = 70;
	localparam int PH_MIN = PH_MIN_A * CUR_LSB_PER_A;
	localparam int PH_MAX = PH_MAX_A * CUR_LSB_PER_A;
	localparam int CUR_MIN = -32768;
	localparam int CUR_MAX = 32767;

	// Input-current converter: full scale 800 mV maps to the top code.
	localparam int IIN_FS_MV = 800;
	localparam logic [IIN_W-1:0] IIN_FS_CODE = IIN_W'((1 << ADC_W) - 1);
	// Digital gain has 0.5 per step, hence the extra bit of shift.
	localparam int IIN_SHIFT = ADC_W + 1 - CUR_FRAC;

	// Selector value that picks the channel total.
	localparam logic [SEL_W-1:0] PH_ALL = 8'hFF;

	// Reset values.
	localparam logic [SEL_W-1:0] SEL_RST = 8'hFF;
	localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0100;
	localparam logic [FEG_W-1:0] FEG_RST = 4'h0;
	localparam logic [DG_W-1:0] DG_RST = 8'h02;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] A_SEL = 8'h00;
	localparam logic [ADDR_W-1:0] A_GAIN0 = 8'h04;
	localparam logic [ADDR_W-1:0] A_GAIN1 = 8'h08;
	localparam logic [ADDR_W-1:0] A_ICAL = 8'h0C;
	localparam logic [ADDR_W-1:0] A_PHASE = 8'h10;
	localparam logic [ADDR_W-1:0] A_IOUT0 = 8'h40;
	localparam logic [ADDR_W-1:0] A_IOUT1 = 8'h44;
	localparam logic [ADDR_W-1:0] A_POUT0 = 8'h48;
	localparam logic [ADDR_W-1:0] A_POUT1 = 8'h4C;
	localparam logic [ADDR_W-1:0] A_VOUT0 = 8'h50;
	localparam logic [ADDR_W-1:0] A_VOUT1 = 8'h54;
	localparam logic [ADDR_W-1:0] A_TEMP0 = 8'h58;
	localparam logic [ADDR_W-1:0] A_TEMP1 = 8'h5C;
	localparam logic [ADDR_W-1:0] A_VIN = 8'h60;
	localparam logic [ADDR_W-1:0] A_IIN = 8'h64;
	localparam logic [ADDR_W-1:0] A_PIN = 8'h68;
	localparam logic [ADDR_W-1:0] A_STAT = 8'h6C;

	// Latest digitized samples from the converters.
	typedef struct packed {
		logic [NPH-1:0][ADC_W-1:0] ph_sense;
		logic [ADC_W-1:0] vref;
		logic [NCH-1:0][TEL_W-1:0] vout;
		logic [NCH-1:0][TEL_W-1:0] temp;
		logic [TEL_W-1:0] vin;
		logic [IIN_W-1:0] iin_code;
	} tcc_samples_t;

	typedef enum logic [1:0] {
		D_LOAD = 2'b00,
		D_RUN = 2'b01,
		D_DONE = 2'b10
	} tcc_dstate_t;

	// Whole state of the calculator.
	typedef struct packed {
		logic [NCH-1:0][SEL_W-1:0] sel;
		logic [NCH-1:0][GAIN_W-1:0] gain;
		logic [FEG_W-1:0] fe_gain;
		logic [DG_W-1:0] dig_gain;
		logic [CUR_W-1:0] input_current_offset;
		logic [NPH-1:0] ph_en;
		logic [NPH-1:0] ph_ch;
		logic [NPH-1:0][IDX_W-1:0] ph_idx;
		logic [NPH-1:0][CUR_W-1:0] ph_ofs;
		tcc_dstate_t dstate;
		logic dch;
		logic [4:0] cnt;
		logic dneg;
		logic dsingle;
		logic [OSUM_W-1:0] dosum;
		logic [REM_W-1:0] rem;
		logic [DIV_W-1:0] quo;
		logic [NCH-1:0][CUR_W-1:0] iout;
		logic [NCH-1:0][31:0] pout;
		logic [CUR_W-1:0] iin;
		logic [31:0] pin;
		logic iin_over;
		logic [31:0] rdata;
	} tcc_state_t;
endpackage : tcc_pkg
`default_nettype wire

// file: hdl/tcc_telemetry_calc.sv
// Telemetry computation and calibration core with its APB register file.
`timescale 1ns/1ps
`default_nettype none
module tcc_telemetry_calc (
	input wire logic pclk, // Core clock, 20 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [tcc_pkg::ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB write byte strobes.
	output logic [31:0] prdata, // APB read data, registered.
	output logic pready, // APB ready, no wait states.
	output logic pslverr, // APB error for unmapped or read-only.
	input wire tcc_pkg::tcc_samples_t samples, // Latest converter codes.
	output logic [tcc_pkg::FEG_W-1:0] input_frontend_gain // Front-end gain.
);
	import tcc_pkg::*;

	tcc_state_t s_reg;
	tcc_state_t s_next;
	logic signed [ADC_W:0] diff [NPH];
	logic [NPH-1:0] in_ch;
	logic [NPH-1:0] picked;
	logic [SEL_W-1:0] cur_sel;
	logic signed [SUM_W-1:0] sum_diff;
	logic signed [OSUM_W-1:0] sum_ofs;
	logic signed [DIV_W-1:0] num;
	logic [REM_W-1:0] trial;
	logic signed [RES_W-1:0] qsig;
	logic signed [RES_W-1:0] res;
	logic signed [RES_W-1:0] lo;
	logic signed [RES_W-1:0] hi;
	logic [ADC_W-1:0] code_sat;
	logic [ADC_W+DG_W-1:0] iprod;
	logic signed [IINS_W-1:0] isum;
	logic rd_hit;
	logic wr_hit;
	logic ph_hit;
	logic [IDX_W-1:0] ph_sel;
	logic [ADDR_W-1:0] ph_off;
	logic [31:0] rd_data;
	logic [31:0] ph_word;

	// Merge write data into an old word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// Reference-subtracted sense and channel membership, one set per phase.
	assign cur_sel = s_reg.sel[s_reg.dch];
	generate
		for (genvar p = 0; p < NPH; p++) begin : g_phase
			assign diff[p] = $signed({1'b0, samples.ph_sense[p]})
				- $signed({1'b0, samples.vref});
			assign in_ch[p] = s_reg.ph_en[p]
				&& (s_reg.ph_ch[p] == s_reg.dch);
			assign picked[p] = in_ch[p] && ((cur_sel == PH_ALL)
				|| (cur_sel == SEL_W'(s_reg.ph_idx[p])));
		end
	endgenerate

	// Sums over the picked phases; a single pick degenerates to one term.
	// Duplicate indices in one channel are all summed, by intent.
	always_comb begin
		sum_diff = '0;
		sum_ofs = '0;
		for (int p = 0; p < NPH; p++) begin
			if (picked[p]) begin
				sum_diff = sum_diff + SUM_W'(diff[p]);
				sum_ofs = sum_ofs + OSUM_W'($signed(s_reg.ph_ofs[p]));
			end
		end
	end

	// Gain is 8.8 fixed point, so the dividend is scaled up by the fraction.
	assign num = {sum_diff, {GAIN_FRAC{1'b0}}};
	assign trial = {s_reg.rem[GAIN_W-1:0], s_reg.quo[DIV_W-1]};

	// Signed quotient plus offset, clamped to the reading's span.
	// A zero gain gives an all-ones quotient, which saturates harmlessly.
	always_comb begin
		qsig = $signed({3'b000, s_reg.quo});
		if (s_reg.dneg) begin
			qsig = -qsig;
		end
		res = qsig + RES_W'($signed(s_reg.dosum));
		lo = s_reg.dsingle ? RES_W'(PH_MIN) : RES_W'(CUR_MIN);
		hi = s_reg.dsingle ? RES_W'(PH_MAX) : RES_W'(CUR_MAX);
	end

	// Input current path; codes above full scale are pinned to the top.
	// The shift truncates under one step; it spares a second divider.
	assign code_sat = (samples.iin_code > IIN_FS_CODE) ?
		IIN_FS_CODE[ADC_W-1:0] : samples.iin_code[ADC_W-1:0];
	assign iprod = code_sat * s_reg.dig_gain;
	assign isum = IINS_W'($signed({1'b0, iprod >> IIN_SHIFT}))
		+ IINS_W'($signed(s_reg.input_current_offset));

	// Phase configuration window decode.
	// Unaligned addresses match no word here and are refused.
	assign ph_off = paddr - A_PHASE;
	assign ph_hit = (paddr >= A_PHASE) && (ph_off < ADDR_W'(4 * NPH))
		&& (paddr[1:0] == 2'b00);
	assign ph_sel = ph_off[IDX_W+1:2];
	assign ph_word = {s_reg.ph_ofs[ph_sel], 9'h000, s_reg.ph_idx[ph_sel],
		2'b00, s_reg.ph_ch[ph_sel], s_reg.ph_en[ph_sel]};

	// Read mux and map; telemetry words refuse writes.
	always_comb begin
		rd_hit = 1'b1;
		wr_hit = 1'b1;
		rd_data = '0;
		case (paddr)
			A_SEL: rd_data = {16'h0000, s_reg.sel[1], s_reg.sel[0]};
			A_GAIN0: rd_data = {16'h0000, s_reg.gain[0]};
			A_GAIN1: rd_data = {16'h0000, s_reg.gain[1]};
			A_ICAL: rd_data = {s_reg.input_current_offset, s_reg.dig_gain, 4'h0,
				s_reg.fe_gain};
			A_IOUT0, A_IOUT1, A_POUT0, A_POUT1, A_VOUT0, A_VOUT1,
			A_TEMP0, A_TEMP1, A_VIN, A_IIN, A_PIN, A_STAT: begin
				wr_hit = 1'b0;
				case (paddr)
					A_IOUT0: rd_data = {16'h0000, s_reg.iout[0]};
					A_IOUT1: rd_data = {16'h0000, s_reg.iout[1]};
					A_POUT0: rd_data = s_reg.pout[0];
					A_POUT1: rd_data = s_reg.pout[1];
					A_VOUT0: rd_data = {16'h0000, samples.vout[0]};
					A_VOUT1: rd_data = {16'h0000, samples.vout[1]};
					A_TEMP0: rd_data = {16'h0000, samples.temp[0]};
					A_TEMP1: rd_data = {16'h0000, samples.temp[1]};
					A_VIN: rd_data = {16'h0000, samples.vin};
					A_IIN: rd_data = {16'h0000, s_reg.iin};
					A_PIN: rd_data = s_reg.pin;
					default: rd_data = {31'h00000000, s_reg.iin_over};
				endcase
			end
			default: begin
				if (ph_hit) begin
					rd_data = ph_word;
				end else begin
					rd_hit = 1'b0;
					wr_hit = 1'b0;
				end
			end
		endcase
	end

	// Next state: bus writes, divider sequence and live products.
	always_comb begin
		logic [31:0] w;
		w = '0;
		s_next = s_reg;

		// Read data is captured in setup so the access phase needs no wait.
		if (psel && !penable) begin
			s_next.rdata = rd_data;
		end

		// Writes land only in the access phase of a mapped control word.
		if (psel && penable && pwrite && wr_hit) begin
			case (paddr)
				A_SEL: begin
					w = merge({16'h0000, s_reg.sel[1], s_reg.sel[0]}, pwdata,
						pstrb);
					s_next.sel[0] = w[7:0];
					s_next.sel[1] = w[15:8];
				end
				A_GAIN0: begin
					w = merge({16'h0000, s_reg.gain[0]}, pwdata, pstrb);
					s_next.gain[0] = w[15:0];
				end
				A_GAIN1: begin
					w = merge({16'h0000, s_reg.gain[1]}, pwdata, pstrb);
					s_next.gain[1] = w[15:0];
				end
				A_ICAL: begin
					w = merge({s_reg.input_current_offset, s_reg.dig_gain, 4'h0,
						s_reg.fe_gain}, pwdata, pstrb);
					s_next.fe_gain = w[3:0];
					s_next.dig_gain = w[15:8];
					s_next.input_current_offset = w[31:16];
				end
				default: begin
					w = merge(ph_word, pwdata, pstrb);
					s_next.ph_en[ph_sel] = w[0];
					s_next.ph_ch[ph_sel] = w[1];
					s_next.ph_idx[ph_sel] = w[6:4];
					s_next.ph_ofs[ph_sel] = w[31:16];
				end
			endcase
		end

		// Divider runs without pause, alternating channels.
		case (s_reg.dstate)
			D_LOAD: begin
				// Selector and offsets freeze here for the whole pass.
				s_next.dneg = num[DIV_W-1];
				s_next.quo = num[DIV_W-1] ? DIV_W'(-num) : num;
				s_next.rem = '0;
				s_next.cnt = '0;
				s_next.dosum = sum_ofs;
				s_next.dsingle = (cur_sel != PH_ALL);
				s_next.dstate = D_RUN;
			end
			D_RUN: begin
				// One restoring step: subtract the channel gain if it fits.
				// A gain written mid-pass spoils only this one result.
				if (trial >= {1'b0, s_reg.gain[s_reg.dch]}) begin
					s_next.rem = trial - {1'b0, s_reg.gain[s_reg.dch]};
					s_next.quo = {s_reg.quo[DIV_W-2:0], 1'b1};
				end else begin
					s_next.rem = trial;
					s_next.quo = {s_reg.quo[DIV_W-2:0], 1'b0};
				end
				s_next.cnt = s_reg.cnt + 5'h01;
				if (s_reg.cnt == DIV_LAST) begin
					s_next.dstate = D_DONE;
				end
			end
			D_DONE: begin
				// Clamping keeps an overrange sum from wrapping its sign.
				if (res < lo) begin
					s_next.iout[s_reg.dch] = CUR_W'(lo);
				end else if (res > hi) begin
					s_next.iout[s_reg.dch] = CUR_W'(hi);
				end else begin
					s_next.iout[s_reg.dch] = CUR_W'(res);
				end
				s_next.dch = ~s_reg.dch;
				s_next.dstate = D_LOAD;
			end
			default: s_next.dstate = D_LOAD;
		endcase

		// Products track the latest readings every cycle.
		for (int c = 0; c < NCH; c++) begin
			s_next.pout[c] = 32'($signed({1'b0, samples.vout[c]})
				* $signed(s_reg.iout[c]));
		end
		if (isum > IINS_W'(CUR_MAX)) begin
			s_next.iin = CUR_W'(CUR_MAX);
		end else if (isum < IINS_W'(CUR_MIN)) begin
			s_next.iin = CUR_W'(CUR_MIN);
		end else begin
			s_next.iin = CUR_W'(isum);
		end
		s_next.pin = 32'($signed({1'b0, samples.vin})
			* $signed(s_reg.iin));
		s_next.iin_over = (samples.iin_code > IIN_FS_CODE);
	end

	// State register; reset loads only constants.
	// Output currents restart from zero until their channel's first pass completes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.sel <= {NCH{SEL_RST}};
			s_reg.gain <= {NCH{GAIN_RST}};
			s_reg.fe_gain <= FEG_RST;
			s_reg.dig_gain <= DG_RST;
			s_reg.dstate <= D_LOAD;
		end else begin
			s_reg <= s_next;
		end
	end

	// Bus answers: zero wait states, error on unmapped or read-only writes.
	assign pready = 1'b1;
	assign pslverr = psel && penable && (pwrite ? !wr_hit : !rd_hit);
	assign prdata = s_reg.rdata;
	assign input_frontend_gain = s_reg.fe_gain;
endmodule : tcc_telemetry_calc
`default_nettype wire

// file: dv/tcc_calc_properties.sv
// Port-level assertions for the telemetry calculator.
`timescale 1ns/1ps
`default_nettype none
module tcc_calc_properties import tcc_pkg::*; (
	input wire logic pclk, // Core clock.
	input wire logic presetn, // Reset, active low.
	input wire logic psel, // Select.
	input wire logic penable, // Access phase.
	input wire logic pwrite, // Direction.
	input wire logic [ADDR_W-1:0] paddr, // Byte address.
	input wire logic [31:0] prdata, // Read data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire tcc_samples_t samples, // Converter codes.
	input wire logic [FEG_W-1:0] input_frontend_gain // Front-end gain.
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A read is a setup cycle followed by its access cycle.
	sequence s_rd(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a ##1 psel && penable;
	endsequence
	sequence s_acc;
		psel && penable;
	endsequence
	a_ready_high: assert property (pready)
		else $error("ready low");
	a_err_in_access: assert property (pslverr |-> s_acc)
		else $error("error outside access");
	a_telem_readonly: assert property (psel && penable && pwrite
		&& paddr >= A_IOUT0 && paddr <= A_STAT |-> pslverr)
		else $error("telemetry write accepted");
	a_unaligned_err: assert property (psel && penable
		&& paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access accepted");
	a_vout_raw: assert property (s_rd(A_VOUT0) |->
		prdata == {16'h0000, $past(samples.vout[0])})
		else $error("output voltage altered");
	a_vin_raw: assert property (s_rd(A_VIN) |->
		prdata == {16'h0000, $past(samples.vin)})
		else $error("input voltage altered");
	a_fegain_cause: assert property ($changed(input_frontend_gain) |->
		$past(psel && penable && pwrite && paddr == A_ICAL))
		else $error("front-end gain changed without write");
	a_rdata_stands: assert property (s_acc ##1 !psel |->
		$stable(prdata))
		else $error("read data moved while idle");
endmodule : tcc_calc_properties
bind tcc_telemetry_calc tcc_calc_properties u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.samples(samples), .input_frontend_gain(input_frontend_gain));
`default_nettype wire

// file: dv/tcc_host_model.sv
// Register bus master standing in for the management host.
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
	input wire logic pclk, // Core clock.
	input wire logic pready, // Slave ready.
	input wire logic [31:0] prdata, // Read data.
	input wire logic pslverr, // Slave error.
	output logic psel, // Select.
	output logic penable, // Access phase.
	output logic pwrite, // Direction.
	output logic [7:0] paddr, // Byte address.
	output logic [31:0] pwdata, // Write data.
	output logic [3:0] pstrb // Strobes, whole words only.
);
	// Bus idles at time zero.
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	// Request held until ready is seen; one idle edge keeps drives apart.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer
endmodule : tcc_host_model
`default_nettype wire

// file: dv/telemetry_calibration_calc_test.sv
// Self-checking bench for the telemetry calculator.
`timescale 1ns/1ps
`default_nettype none
module telemetry_calibration_calc_test;
	import tcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, fe_gain;
	tcc_samples_t samples;
	int miscompares, check_count;
	tcc_host_model host (.pclk(pclk), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	tcc_telemetry_calc uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .samples(samples),
		.input_frontend_gain(fe_gain));
	// 20 MHz clock.
	initial pclk = 1'h0;
	always #25 pclk = ~pclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// One access; reads compare data, every access compares the error.
	task automatic acc(input int w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] x, input int xe);
		logic [31:0] q;
		logic e;
		host.xfer(1'(w), a, d, q, e);
		if (w == 0)
			check(q, x);
		check({31'h0, e}, xe);
	endtask : acc
	// Divider round trip is under 80 cycles; wait a little more.
	task automatic settle();
		repeat (100) @(posedge pclk);
	endtask : settle
	task automatic sc_reset();
		acc(0, A_SEL, 0, 32'h0000FFFF, 0);
		acc(0, A_GAIN0, 0, 32'h100, 0);
		acc(0, A_ICAL, 0, 32'h200, 0);
	endtask : sc_reset
	// Phases 0,1 on channel 0 with offsets +1 A and -0.5 A; phase 2 on 1.
	task automatic sc_total();
		acc(1, A_PHASE, 32'h00100001, 0, 0);
		acc(1, A_PHASE + 8'h04, 32'hFFF80011, 0, 0);
		acc(1, A_PHASE + 8'h08, 32'h00000003, 0, 0);
		settle();
		acc(0, A_IOUT0, 0, 32'h58, 0);
		acc(0, A_IOUT1, 0, 32'h10, 0);
		acc(0, A_POUT0, 0, 32'h5800, 0);
		acc(0, A_POUT1, 0, 32'h2000, 0);
	endtask : sc_total
	task automatic sc_phase();
		acc(1, A_SEL, 32'h0000FF01, 0, 0);
		settle();
		acc(0, A_IOUT0, 0, 32'h28, 0);
		acc(1, A_SEL, 32'h0000FF00, 0, 0);
		samples.ph_sense[0] <= 12'hFD0;
		settle();
		acc(0, A_IOUT0, 0, 32'h460, 0);
		samples.ph_sense[0] <= 12'h700;
		settle();
		acc(0, A_IOUT0, 0, 32'hFF60, 0);
		samples.ph_sense[0] <= 12'h820;
		settle();
		acc(0, A_IOUT0, 0, 32'h30, 0);
		acc(1, A_SEL, 32'h0000FFFF, 0, 0);
	endtask : sc_phase
	// Host gain recalibration: known loads 4 A apart read 2 A apart.
	task automatic sc_gain();
		logic [31:0] m1, m2, g;
		logic e;
		settle();
		host.xfer(1'b0, A_IOUT0, 32'h0, m1, e);
		check(m1, 32'h58);
		samples.ph_sense[1] <= 12'h850;
		settle();
		host.xfer(1'b0, A_IOUT0, 32'h0, m2, e);
		check(m2 - m1, 32'h20);
		g = (32'h40 * 32'h100) / (m2 - m1);
		samples.ph_sense[1] <= 12'h830;
		acc(1, A_GAIN0, g, 0, 0);
		settle();
		acc(0, A_IOUT0, 0, 32'h30, 0);
		acc(0, A_IOUT1, 0, 32'h10, 0);
		acc(1, A_GAIN0, 32'h100, 0, 0);
		samples.vref <= 12'h810;
		settle();
		acc(0, A_IOUT0, 0, 32'h38, 0);
		samples.vref <= 12'h800;
		settle();
	endtask : sc_gain
	// Phase 0 isolated by disabling phase 1; it keeps index zero.
	// Its offset is then recalibrated against a known 4 A load.
	task automatic sc_offset();
		logic [31:0] m, o;
		logic e;
		acc(1, A_PHASE + 8'h04, 32'hFFF80010, 0, 0);
		settle();
		host.xfer(1'b0, A_IOUT0, 32'h0, m, e);
		check(m, 32'h30);
		o = 32'h60 - (m + 32'h10);
		acc(1, A_PHASE, {o[15:0], 16'h0001}, 0, 0);
		acc(1, A_PHASE + 8'h04, 32'hFFF80011, 0, 0);
		settle();
		acc(0, A_IOUT0, 0, 32'h68, 0);
		acc(1, A_PHASE, 32'h00100001, 0, 0);
		settle();
	endtask : sc_offset
	// Offset 1 A, digital gain 2.0, then over-range code, then gain 0.5.
	task automatic sc_iin();
		acc(1, A_ICAL, 32'h00100405, 0, 0);
		check({28'h0, fe_gain}, 32'h5);
		acc(0, A_IIN, 0, 32'h18, 0);
		acc(0, A_PIN, 0, 32'h960, 0);
		samples.iin_code <= 13'h1800;
		repeat (4) @(posedge pclk);
		acc(0, A_IIN, 0, 32'h2F, 0);
		acc(0, A_STAT, 0, 32'h1, 0);
		samples.iin_code <= 13'h0400;
		acc(1, A_ICAL, 32'h00100105, 0, 0);
		acc(0, A_IIN, 0, 32'h12, 0);
	endtask : sc_iin
	task automatic sc_raw();
		acc(0, A_VOUT0, 0, 32'h100, 0);
		acc(0, A_TEMP1, 0, 32'h123, 0);
		acc(0, A_VIN, 0, 32'h64, 0);
		acc(1, A_IOUT0, 32'h5, 0, 1);
		acc(0, A_IOUT0, 0, 32'h58, 0);
		acc(0, 8'h80, 0, 32'h0, 1);
		acc(0, 8'h41, 0, 32'h0, 1);
		acc(0, A_SEL, 0, 32'h0000FFFF, 0);
	endtask : sc_raw
	// Fixed converter codes, reset, then the scenarios in turn.
	initial begin
		samples = '0;
		samples.vref = 12'h800;
		samples.ph_sense[0] = 12'h820;
		samples.ph_sense[1] = 12'h830;
		samples.ph_sense[2] = 12'h810;
		samples.vout[0] = 16'h0100;
		samples.vout[1] = 16'h0200;
		samples.temp[1] = 16'h0123;
		samples.vin = 16'h0064;
		samples.iin_code = 13'h0400;
		presetn = 1'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		sc_reset();
		sc_total();
		sc_phase();
		sc_gain();
		sc_offset();
		sc_iin();
		sc_raw();
		stop_test();
	end
	// Whole run needs about 1450 cycles; a hang is cut well beyond that.
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		stop_test();
	end
endmodule : telemetry_calibration_calc_test
`default_nettype wire
